// [hw/rtc_ctrl_defs.vh]
// register map, field positions, reset values and counts of the counter block
// assumes: included by bare name by the prescaler and control/status design files of the block
`ifndef RTC_CTRL_DEFS_VH
`define RTC_CTRL_DEFS_VH

// register byte offsets
`define CTL_OFF          8'h00
`define CNT_LO_OFF       8'h04
`define CNT_HI_OFF       8'h08
`define MAT_LO_OFF       8'h0c
`define MAT_HI_OFF       8'h10
`define STAT_OFF         8'h14
`define MASK_OFF         8'h18
`define INFO_OFF         8'h1c

// control register fields
`define CTL_BLK_RST      7
`define CTL_CNT_EN       6
`define CTL_WAKE_MAT     5
`define CTL_XMODE_HI     4
`define CTL_XMODE_LO     3
`define CTL_CLR_ON_MAT   2
`define CTL_CNT_CLR_N    1
`define CTL_XTAL_SEL     0
`define CTL_RESET        8'h00

// status and mask fields
`define ST_MATCH         0
`define ST_TICK          1
`define ST_WIDTH         2
`define ST_RESET         2'h0

// counter and prescaler
`define CNT_WIDTH        40
`define PRE_WIDTH        6
`define PRE_LAST         6'h3f
`define REL_CYCLES       2

`endif

// [hw/level_sync.v]
// two-flop synchroniser for a level from outside the core clock domain
// assumes: the first flop feeds only the second
`timescale 1ns/100ps
module level_sync
(
   input  wire core_clk,
   input  wire arst_n,
   input  wire din,
   output reg  dout
);

reg meta_r;

always @(posedge core_clk or negedge arst_n)
begin
   if (!arst_n)
   begin
      meta_r <= 1'b0;
      dout   <= 1'b0;
   end
   else
   begin
      meta_r <= din;
      dout   <= meta_r;
   end
end

endmodule // level_sync

// [hw/edge_prescaler.v]
// divides timebase edges by 64 into a one-cycle tick
// assumes: edge_in is a one-cycle pulse in the core clock domain
`timescale 1ns/100ps
`include "rtc_ctrl_defs.vh"
module edge_prescaler
(
   input  wire core_clk,
   input  wire arst_n,
   input  wire run,
   input  wire edge_in,
   output reg  tick_r
);

reg [`PRE_WIDTH-1:0] cnt_r;

always @(posedge core_clk or negedge arst_n)
begin
   if (!arst_n)
   begin
      cnt_r  <= {`PRE_WIDTH{1'b0}};
      tick_r <= 1'b0;
   end
   else if (!run)
   begin
      // stopped prescaler restarts from zero on the next enable
      cnt_r  <= {`PRE_WIDTH{1'b0}};
      tick_r <= 1'b0;
   end
   else if (edge_in)
   begin
      if (cnt_r == `PRE_LAST)
      begin
         cnt_r  <= {`PRE_WIDTH{1'b0}};
         tick_r <= 1'b1;
      end
      else
      begin
         cnt_r  <= cnt_r + {{(`PRE_WIDTH-1){1'b0}}, 1'b1};
         tick_r <= 1'b0;
      end
   end
   else
   begin
      tick_r <= 1'b0;
   end
end

endmodule // edge_prescaler

// [hw/rtc_control_status.v]
// control/status logic of the real-time counter with an apb register slave
// assumes: apb master on core_clk; timebase_clock is a slow free clock pin
//
// Notes on behaviour
// - control bit 7 resets counter block; release two bus clocks after clearing
// - counting runs only when enable bit 6 is set and block reset is off
// - first increment comes after 64 rising timebase edges from enable
// - clearing enable stops prescaler, counter value is kept
// - counter loads from software only while enable is cleared
// - wake-on-match bit 5 drives both match outputs high on count equal match
// - power sequencer match output wakes the 1.5 V regulator when connected
// - wake-on-match cleared keeps both match outputs low
// - crystal mode field sits in bits 4:3, reset value 00
// - crystal mode reaches oscillator mode only while crystal select is 1
// - writing 0 to counter clear bit resets the 40-bit counter
// - clear-on-match clears counter at equality, unless match value is zero
//
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/100ps
`include "rtc_ctrl_defs.vh"
module rtc_control_status
(
   input  wire        core_clk,
   input  wire        arst_n,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        timebase_clock,
   output reg         match_out,
   output reg         power_seq_match_out,
   output reg  [1:0]  oscillator_mode,
   output reg         crystal_select,
   output reg         irq
);

////////////////////////////////////////////////////////////////////////////////
// registers and wires

reg  [7:0]              ctl_r;
reg  [`CNT_WIDTH-1:0]   count_r;
reg  [`CNT_WIDTH-1:0]   match_r;
reg  [`ST_WIDTH-1:0]    status_r;
reg  [`ST_WIDTH-1:0]    status_nxt;
reg  [`ST_WIDTH-1:0]    mask_r;
reg  [`ST_WIDTH-1:0]    rd_snap_r;
reg  [`REL_CYCLES-1:0]  rel_r;
reg                     tb_prev_r;
reg  [31:0]             rd_mux;
reg                     rd_hit;

wire                    tb_sync;
wire                    tb_edge;
wire                    tick;
wire                    blk_rst;
wire                    run;
wire                    setup;
wire                    wr_acc;
wire                    rd_acc;
wire                    equal;
wire                    match_nz;
wire                    match_now;

////////////////////////////////////////////////////////////////////////////////
// apb handshake: no wait state, write and read-clear at the access edge

assign setup  = psel & ~penable;
assign wr_acc = psel & penable & pready & pwrite;
assign rd_acc = psel & penable & pready & ~pwrite;

always @*
begin
   rd_mux = 32'h0000_0000;
   rd_hit = 1'b1;
   if (paddr == `CTL_OFF)
   begin
      rd_mux[7:0] = ctl_r;
   end
   else if (paddr == `CNT_LO_OFF)
   begin
      rd_mux = count_r[31:0];
   end
   else if (paddr == `CNT_HI_OFF)
   begin
      rd_mux[7:0] = count_r[`CNT_WIDTH-1:32];
   end
   else if (paddr == `MAT_LO_OFF)
   begin
      rd_mux = match_r[31:0];
   end
   else if (paddr == `MAT_HI_OFF)
   begin
      rd_mux[7:0] = match_r[`CNT_WIDTH-1:32];
   end
   else if (paddr == `STAT_OFF)
   begin
      rd_mux[`ST_WIDTH-1:0] = status_r;
   end
   else if (paddr == `MASK_OFF)
   begin
      rd_mux[`ST_WIDTH-1:0] = mask_r;
   end
   else if (paddr == `INFO_OFF)
   begin
      rd_mux[0] = blk_rst;
      rd_mux[1] = run;
      rd_mux[2] = match_now;
   end
   else
   begin
      rd_hit = 1'b0;
   end
end

always @(posedge core_clk or negedge arst_n)
begin
   if (!arst_n)
   begin
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      prdata    <= 32'h0000_0000;
      rd_snap_r <= `ST_RESET;
   end
   else
   begin
      pready  <= setup;
      pslverr <= setup & ~rd_hit;
      if (setup)
      begin
         prdata    <= pwrite ? 32'h0000_0000 : rd_mux;
         rd_snap_r <= (!pwrite && paddr == `STAT_OFF) ? status_r : `ST_RESET;
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// control, match and mask registers

always @(posedge core_clk or negedge arst_n)
begin
   if (!arst_n)
   begin
      ctl_r   <= `CTL_RESET;
      match_r <= {`CNT_WIDTH{1'b0}};
      mask_r  <= `ST_RESET;
   end
   else if (wr_acc)
   begin
      if (paddr == `CTL_OFF)
      begin
         ctl_r <= pwdata[7:0];
      end
      else if (paddr == `MAT_LO_OFF)
      begin
         match_r[31:0] <= pwdata;
      end
      else if (paddr == `MAT_HI_OFF)
      begin
         match_r[`CNT_WIDTH-1:32] <= pwdata[7:0];
      end
      else if (paddr == `MASK_OFF)
      begin
         mask_r <= pwdata[`ST_WIDTH-1:0];
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// block reset with delayed release

always @(posedge core_clk or negedge arst_n)
begin
   if (!arst_n)
   begin
      rel_r <= {`REL_CYCLES{1'b0}};
   end
   else
   begin
      rel_r <= {rel_r[`REL_CYCLES-2:0], ctl_r[`CTL_BLK_RST]};
   end
end

assign blk_rst = ctl_r[`CTL_BLK_RST] | (|rel_r);
assign run     = ctl_r[`CTL_CNT_EN] & ~blk_rst;

////////////////////////////////////////////////////////////////////////////////
// timebase edge detection and prescaler

level_sync u_tb_sync
(
   .core_clk (core_clk),
   .arst_n   (arst_n),
   .din      (timebase_clock),
   .dout     (tb_sync)
);

always @(posedge core_clk or negedge arst_n)
begin
   if (!arst_n)
   begin
      tb_prev_r <= 1'b0;
   end
   else
   begin
      tb_prev_r <= tb_sync;
   end
end

assign tb_edge = tb_sync & ~tb_prev_r;

edge_prescaler u_pre
(
   .core_clk (core_clk),
   .arst_n   (arst_n),
   .run      (run),
   .edge_in  (tb_edge),
   .tick_r   (tick)
);

////////////////////////////////////////////////////////////////////////////////
// 40-bit counter

assign equal    = (count_r == match_r);
assign match_nz = |match_r;

always @(posedge core_clk or negedge arst_n)
begin
   if (!arst_n)
   begin
      count_r <= {`CNT_WIDTH{1'b0}};
   end
   else if (blk_rst || !ctl_r[`CTL_CNT_CLR_N])
   begin
      count_r <= {`CNT_WIDTH{1'b0}};
   end
   else if (wr_acc && !ctl_r[`CTL_CNT_EN] && paddr == `CNT_LO_OFF)
   begin
      count_r[31:0] <= pwdata;
   end
   else if (wr_acc && !ctl_r[`CTL_CNT_EN] && paddr == `CNT_HI_OFF)
   begin
      count_r[`CNT_WIDTH-1:32] <= pwdata[7:0];
   end
   else if (tick && run)
   begin
      if (ctl_r[`CTL_CLR_ON_MAT] && match_nz && equal)
      begin
         count_r <= {`CNT_WIDTH{1'b0}};
      end
      else
      begin
         count_r <= count_r + {{(`CNT_WIDTH-1){1'b0}}, 1'b1};
      end
   end
   // otherwise the value is held while stopped
end

////////////////////////////////////////////////////////////////////////////////
// match outputs, oscillator controls

assign match_now = ctl_r[`CTL_WAKE_MAT] & equal;

always @(posedge core_clk or negedge arst_n)
begin
   if (!arst_n)
   begin
      match_out           <= 1'b0;
      power_seq_match_out <= 1'b0;
      oscillator_mode     <= 2'b00;
      crystal_select      <= 1'b0;
   end
   else
   begin
      match_out           <= match_now;
      power_seq_match_out <= match_now;
      crystal_select      <= ctl_r[`CTL_XTAL_SEL];
      oscillator_mode     <= ctl_r[`CTL_XTAL_SEL] ?
                             ctl_r[`CTL_XMODE_HI:`CTL_XMODE_LO] : 2'b00;
   end
end

////////////////////////////////////////////////////////////////////////////////
// sticky status, read clears reported bits, new events win

always @*
begin
   status_nxt = status_r;
   if (rd_acc && paddr == `STAT_OFF)
   begin
      status_nxt = status_nxt & ~rd_snap_r;
   end
   if (match_now && !match_out)
   begin
      status_nxt[`ST_MATCH] = 1'b1;
   end
   if (tick && run)
   begin
      status_nxt[`ST_TICK] = 1'b1;
   end
end

always @(posedge core_clk or negedge arst_n)
begin
   if (!arst_n)
   begin
      status_r <= `ST_RESET;
      irq      <= 1'b0;
   end
   else
   begin
      status_r <= status_nxt;
      irq      <= |(status_nxt & mask_r);
   end
end

endmodule // rtc_control_status

// [tb/rtc_ctl_asserts.sv]
// concurrent checks on the control/status block, seen from its ports
// assumes: bound to rtc_control_status from tb_top
`timescale 1ns/100ps
`include "rtc_ctrl_defs.vh"
module rtc_ctl_asserts
(
   input wire        core_clk,
   input wire        arst_n,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [7:0]  paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   input wire        match_out,
   input wire        power_seq_match_out,
   input wire [1:0]  oscillator_mode,
   input wire        crystal_select
);
   reg       wake_r;
   reg       sel_r;
   reg [1:0] mode_r;
   wire      ctl_wr = psel && penable && pready && pwrite && paddr == `CTL_OFF;

   // shadow of the control fields as software last wrote them
   always @(posedge core_clk or negedge arst_n)
      if (!arst_n)
         {wake_r, mode_r, sel_r} <= 4'h0;
      else if (ctl_wr)
         {wake_r, mode_r, sel_r} <= {pwdata[5], pwdata[4:3], pwdata[0]};

   default clocking @(posedge core_clk); endclocking
   default disable iff (!arst_n);

   sequence setup_s;
      psel && !penable;
   endsequence
   sequence access_s;
      psel && penable && pready;
   endsequence

   a_answer_next: assert property (setup_s |=> access_s)
      else $error("no answer after setup");
   a_ready_once: assert property (access_s |=> !pready)
      else $error("ready held too long");
   a_err_read: assert property (pslverr && !pwrite |-> pready && prdata == 32'h0)
      else $error("bad error answer");
   a_match_pair: assert property (match_out == power_seq_match_out)
      else $error("match outputs differ");
   a_wake_off: assert property (!wake_r [*2] |-> !match_out)
      else $error("match while wake off");
   a_osc_gate: assert property (!$past(sel_r) |-> oscillator_mode == 2'h0)
      else $error("mode without select");
   a_osc_mode: assert property ($past(sel_r) |-> oscillator_mode == $past(mode_r))
      else $error("mode differs");
   a_sel_copy: assert property (crystal_select == $past(sel_r))
      else $error("select differs");
endmodule // rtc_ctl_asserts

// [tb/far_side_model.sv]
// far side: free-running timebase crystal and regulator power sequencer
// assumes: power_seq_match_out comes from the block under test
`timescale 1ns/100ps
module far_side_model
#(
   parameter HALF_NS = 400
)
(
   output reg  timebase_clock,
   input  wire power_seq_match_out,
   output reg  regulator_on
);
   initial timebase_clock = 1'b0;
   initial regulator_on = 1'b0;
   always #(HALF_NS) timebase_clock = ~timebase_clock;
   // a match from the block switches the regulator on
   always @(posedge power_seq_match_out)
      regulator_on <= 1'b1;
endmodule // far_side_model

// [tb/tb_top.sv]
// self-checking bench for the control/status block over apb
// assumes: far_side_model gives an 800 ns timebase and the sequencer
`timescale 1ns/100ps
`include "rtc_ctrl_defs.vh"
module tb_top;
   reg         core_clk = 1'b0;
   reg         arst_n = 1'b0;
   reg         psel = 1'b0;
   reg         penable = 1'b0;
   reg         pwrite = 1'b0;
   reg  [7:0]  paddr = 8'h00;
   reg  [31:0] pwdata = 32'h0;
   wire [31:0] prdata;
   wire        pready, pslverr, timebase_clock, match_out, power_seq_match_out;
   wire        crystal_select, irq, regulator_on;
   wire [1:0]  oscillator_mode;
   reg  [31:0] q;
   reg         err;
   integer     error_cnt = 0;
   integer     compares = 0;
   integer     cyc = 0;

   always #50 core_clk = ~core_clk;

   rtc_control_status rtc_control_status_i (.core_clk, .arst_n, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .timebase_clock,
      .match_out, .power_seq_match_out, .oscillator_mode, .crystal_select, .irq);
   far_side_model far_side_model_i (.timebase_clock, .power_seq_match_out,
      .regulator_on);

   ////////////////////////////////////////////////////////////
   task chk(input [31:0] got, input [31:0] exp);
   begin
      compares = compares + 1;
      if (got !== exp)
      begin
         error_cnt = error_cnt + 1;
         $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
      end
   end
   endtask

   task close_out;
   begin
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   end
   endtask

   // one apb transfer, held until pready is sampled high
   task apb(input w, input [7:0] a, input [31:0] d);
   begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      // only pready sampled high or the bench timeout ends this wait
      @(posedge core_clk);
      while (pready !== 1'b1)
      begin
         @(posedge core_clk);
      end
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   end
   endtask

   ////////////////////////////////////////////////////////////
   task t_regs;
   begin
      apb(1'b0, `CTL_OFF, 32'h0);
      chk(q, 32'(`CTL_RESET));
      apb(1'b0, 8'h20, 32'h0);
      chk({31'h0, err}, 32'h1);
      chk(q, 32'h0);
      apb(1'b1, `CTL_OFF, 32'h1b);
      apb(1'b0, `CTL_OFF, 32'h0);
      chk(q, 32'h1b);
      chk(32'(oscillator_mode), 32'h3);
      chk(32'(crystal_select), 32'h1);
      apb(1'b1, `CTL_OFF, 32'h12);
      repeat (2) @(posedge core_clk);
      chk(32'(oscillator_mode), 32'h0);
      chk(32'(crystal_select), 32'h0);
   end
   endtask

   task t_blk_rst;
   begin
      apb(1'b1, `CTL_OFF, 32'hc2);
      apb(1'b0, `INFO_OFF, 32'h0);
      chk(32'(q[0]), 32'h1);
      chk(32'(q[1]), 32'h0);
      apb(1'b1, `CTL_OFF, 32'h02);
      // read sampled two edges after the clearing write: still in reset
      apb(1'b0, `INFO_OFF, 32'h0);
      chk(32'(q[0]), 32'h1);
      repeat (3) @(posedge core_clk);
      apb(1'b0, `INFO_OFF, 32'h0);
      chk(32'(q[0]), 32'h0);
   end
   endtask

   // one increment every 64 timebase edges, i.e. about 512 core cycles
   task t_count;
   begin
      apb(1'b1, `CTL_OFF, 32'h42);
      apb(1'b1, `CNT_LO_OFF, 32'h55);
      apb(1'b0, `CNT_LO_OFF, 32'h0);
      chk(q, 32'h0);
      apb(1'b0, `INFO_OFF, 32'h0);
      chk(q, 32'h2);
      repeat (440) @(posedge core_clk);
      apb(1'b0, `CNT_LO_OFF, 32'h0);
      chk(q, 32'h0);
      repeat (100) @(posedge core_clk);
      apb(1'b0, `CNT_LO_OFF, 32'h0);
      chk(q, 32'h1);
      repeat (512) @(posedge core_clk);
      apb(1'b0, `CNT_LO_OFF, 32'h0);
      chk(q, 32'h2);
      apb(1'b1, `CTL_OFF, 32'h02);
      repeat (600) @(posedge core_clk);
      apb(1'b0, `CNT_LO_OFF, 32'h0);
      chk(q, 32'h2);
      apb(1'b1, `CNT_LO_OFF, 32'h55);
      apb(1'b0, `CNT_LO_OFF, 32'h0);
      chk(q, 32'h55);
      apb(1'b1, `CTL_OFF, 32'h0);
      apb(1'b0, `CNT_LO_OFF, 32'h0);
      chk(q, 32'h0);
   end
   endtask

   task t_match;
   begin
      apb(1'b1, `MAT_LO_OFF, 32'h5);
      apb(1'b1, `CTL_OFF, 32'h22);
      apb(1'b1, `MASK_OFF, 32'h0);
      apb(1'b0, `STAT_OFF, 32'h0);
      apb(1'b1, `CNT_LO_OFF, 32'h5);
      repeat (3) @(posedge core_clk);
      chk({match_out, power_seq_match_out, regulator_on, irq}, 32'he);
      apb(1'b1, `MASK_OFF, 32'h1);
      repeat (2) @(posedge core_clk);
      chk(32'(irq), 32'h1);
      apb(1'b0, `STAT_OFF, 32'h0);
      chk(32'(q[0]), 32'h1);
      repeat (2) @(posedge core_clk);
      chk(32'(irq), 32'h0);
      apb(1'b1, `CTL_OFF, 32'h02);
      repeat (2) @(posedge core_clk);
      chk(32'(match_out), 32'h0);
   end
   endtask

   task t_clr_match;
   begin
      apb(1'b1, `CNT_LO_OFF, 32'h3);
      apb(1'b1, `MAT_LO_OFF, 32'h4);
      apb(1'b1, `CTL_OFF, 32'h46);
      repeat (1100) @(posedge core_clk);
      apb(1'b1, `CTL_OFF, 32'h02);
      apb(1'b0, `CNT_LO_OFF, 32'h0);
      chk(q, 32'h0);
      apb(1'b0, `STAT_OFF, 32'h0);
      chk(q, 32'h2);
      chk(32'(irq), 32'h0);
   end
   endtask

   ////////////////////////////////////////////////////////////
   initial
   begin
      repeat (6) @(posedge core_clk);
      arst_n <= 1'b1;
      @(posedge core_clk);
      t_regs;
      t_blk_rst;
      t_count;
      t_match;
      t_clr_match;
      close_out;
   end

   always @(posedge core_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 8000)
      begin
         error_cnt = error_cnt + 1;
         close_out;
      end
   end
endmodule // tb_top

bind rtc_control_status rtc_ctl_asserts rtc_ctl_asserts_i (.core_clk, .arst_n, .psel,
   .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .match_out,
   .power_seq_match_out, .oscillator_mode, .crystal_select);
